// file: see_chk.sv
module see_chk (
    // Clock and reset.
    input logic clk,
    input logic rst,
    // Link pins.
    input logic cs_n,
    input logic sck,
    input logic si,
    input logic hold_n,
    input logic guard_n,
    input logic so_o,
    input logic so_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // --------------------------------------------------------------
    // Output driver timing
    // --------------------------------------------------------------
    idle_off_a: assert property (cs_n [*6] |-> !so_oe) else $error("output on while deselected");
    hold_off_a: assert property (!hold_n [*6] |-> !so_oe) else $error("output on while suspended");
    fall_launch_a: assert property ($changed(so_o) && $past(so_oe) && so_oe |-> $past(!sck, 3))
        else $error("output changed away from a clock fall");
    rise_sel_a: assert property ($rose(so_oe) |-> !cs_n && hold_n) else $error("output on unselected");
    rise_fall_a: assert property ($rose(so_oe) |-> $past(!sck, 3)) else $error("output on off a fall");
    opcode_quiet_a: assert property ($fell(cs_n) |-> ##2 !so_oe [*8]) else $error("output during op");
    oe_stand_a: assert property ($fell(so_oe) |-> cs_n || !hold_n || $past(cs_n, 2) || $past(!hold_n, 2))
        else $error("output dropped while selected");
    reset_quiet_a: assert property ($fell(rst) |-> !so_oe [*3]) else $error("output on after reset");
    cover property ($rose(so_oe));
    cover property (!hold_n && !cs_n);
    cover property ($rose(cs_n) && !guard_n);
endmodule

bind see_top see_chk u_chk (.clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
    .guard_n(guard_n), .so_o(so_o), .so_oe(so_oe));

// file: see_defs.vh
`ifndef SEE_DEFS_VH
`define SEE_DEFS_VH
`define SEE_OP_LATCH_SET    8'h06
`define SEE_OP_LATCH_CLEAR  8'h04
`define SEE_OP_STATUS_READ  8'h05
`define SEE_OP_STATUS_WRITE 8'h01
`define SEE_OP_ARRAY_READ   8'h03
`define SEE_OP_ARRAY_WRITE  8'h02
`define SEE_ST_BUSY         0
`define SEE_ST_LATCH        1
`define SEE_ST_PROT_LO      2
`define SEE_ST_PROT_HI      3
`define SEE_PROT_RESET      2'h0
`define SEE_CLK_KHZ         20000
`define SEE_T_PROG_US       15000
`define SEE_PROG_CYCLES     ((`SEE_T_PROG_US * `SEE_CLK_KHZ) / 1000)
`endif

// file: see_master.sv
module see_master (
    // Clock and returned data.
    input  logic clk,
    input  logic so_o,
    input  logic so_oe,
    // Master-driven link pins.
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic hold_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic oe_seen;
    logic hold_oe;
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
        oe_seen = 1'b0;
        hold_oe = 1'b0;
    end
    // An idle data line keeps moving, so a stale bit is never taken for data.
    always @(posedge clk) begin
        if (cs_n) begin
            si <= ~si;
        end
    end
    task sel();
        @(posedge clk) cs_n <= 1'b0;
        oe_seen = 1'b0;
        repeat (3) @(posedge clk);
    endtask
    // Four clocks low, four high; data is read mid-high, well after the launch.
    task xfer(input logic [7:0] tx, input int nb, input bit hp, output logic [7:0] rx);
        for (int i = 7; i > 7 - nb; i--) begin
            @(posedge clk) si <= tx[i];
            if (hp && i == 4) begin
                hold_n <= 1'b0;
                repeat (8) @(posedge clk);
                @(negedge clk) hold_oe = so_oe;
                @(posedge clk) hold_n <= 1'b1;
                repeat (4) @(posedge clk);
            end
            repeat (3) @(posedge clk);
            sck <= 1'b1;
            repeat (2) @(posedge clk);
            @(negedge clk) rx[i] = so_o;
            oe_seen = oe_seen | so_oe;
            repeat (2) @(posedge clk);
            sck <= 1'b0;
        end
    endtask
    task desel();
        repeat (2) @(posedge clk);
        cs_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask
endmodule

// file: see_prog_timer.v
module see_prog_timer #(
    parameter CYCLES = 300000,
    parameter CW     = 20
) (
    // Clock and reset.
    input  wire clk,
    input  wire rst,
    // Start pulse, busy level and completion pulse.
    input  wire start,
    output reg  busy,
    output reg  done
);
    reg [CW-1:0] cnt_q;

    // ------------------------------------------------------------
    // Self-timed programming counter
    // ------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= {CW{1'b0}};
            busy  <= 1'b0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                cnt_q <= CYCLES[CW-1:0] - 1'b1;
                busy  <= 1'b1;
            end else if (busy) begin
                if (cnt_q == {CW{1'b0}}) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 1'b1;
                end
            end
        end
    end
endmodule

// file: see_sync.v
module see_sync #(
    parameter W = 5
) (
    // Clock and reset.
    input  wire         clk,
    input  wire         rst,
    // Asynchronous levels in, synchronised levels out.
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= {W{1'b1}};
            sync_q <= {W{1'b1}};
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;
endmodule

// file: see_top.v
`include "see_defs.vh"

module see_top #(
    parameter PROG_CYCLES = `SEE_PROG_CYCLES,
    parameter PROG_CW     = 20,
    parameter AW          = 8,
    parameter PAGE_AW     = 2
) (
    // Clock and reset.
    input  wire clk,
    input  wire rst,
    // Serial link pins.
    input  wire cs_n,
    input  wire sck,
    input  wire si,
    input  wire hold_n,
    input  wire guard_n,
    output reg  so_o,
    output reg  so_oe
);
    localparam PH_IDLE  = 3'h0;
    localparam PH_CMD   = 3'h1;
    localparam PH_ADDR  = 3'h2;
    localparam PH_RDAT  = 3'h3;
    localparam PH_WDAT  = 3'h4;
    localparam PH_STOUT = 3'h5;
    localparam PH_STWR  = 3'h6;
    localparam PH_DEAD  = 3'h7;

    localparam PAGE_N = 1 << PAGE_AW;

    // ------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ------------------------------------------------------------
    wire [4:0] pins_s;
    see_sync #(
        .W (5)
    ) u_sync (
        .clk (clk),
        .rst (rst),
        .d   ({cs_n, sck, si, hold_n, guard_n}),
        .q   (pins_s)
    );

    wire cs_s    = pins_s[4];
    wire sck_s   = pins_s[3];
    wire si_s    = pins_s[2];
    wire hold_s  = pins_s[1];
    wire guard_s = pins_s[0];

    reg cs_prev_q;
    reg sck_prev_q;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_prev_q  <= 1'b1;
            // Matches the synchroniser's reset level, so no false clock edge follows reset.
            sck_prev_q <= 1'b1;
        end else begin
            cs_prev_q  <= cs_s;
            sck_prev_q <= sck_s;
        end
    end

    wire cs_fall = cs_prev_q && !cs_s;
    wire cs_rise = !cs_prev_q && cs_s;
    // Edges are ignored while deselected or suspended, which freezes the sequence.
    wire active  = !cs_s && hold_s;
    wire sck_r   = active && sck_s && !sck_prev_q;
    wire sck_f   = active && !sck_s && sck_prev_q;

    // ------------------------------------------------------------
    // Storage and state
    // ------------------------------------------------------------
    reg [7:0]         mem [0:(1<<AW)-1];
    reg [7:0]         page_q [0:PAGE_N-1];
    reg [PAGE_N-1:0]  page_vld_q;
    reg [2:0]         phase_q;
    reg [2:0]         bit_cnt_q;
    reg [6:0]         shin_q;
    reg [7:0]         shout_q;
    reg               out_act_q;
    reg               rd_mode_q;
    reg [AW-1:0]      addr_q;
    reg               wel_q;
    reg [1:0]         prot_q;
    reg [1:0]         prot_new_q;
    reg               prog_arr_q;
    reg               prog_start_q;
    reg               so_d;
    reg               so_oe_d;
    integer           i;

    wire prog_busy;
    wire prog_done;

    see_prog_timer #(
        .CYCLES (PROG_CYCLES),
        .CW     (PROG_CW)
    ) u_timer (
        .clk   (clk),
        .rst   (rst),
        .start (prog_start_q),
        .busy  (prog_busy),
        .done  (prog_done)
    );

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    function is_protected;
        input [AW-1:0] a;
        input [1:0]    lvl;
        begin
            case (lvl)
                2'h0:    is_protected = 1'b0;
                2'h1:    is_protected = (a[AW-1:AW-2] == 2'h3);
                2'h2:    is_protected = a[AW-1];
                default: is_protected = 1'b1;
            endcase
        end
    endfunction

    function is_out_phase;
        input [2:0] ph;
        begin
            is_out_phase = (ph == PH_RDAT) || (ph == PH_STOUT);
        end
    endfunction

    function [7:0] status_byte;
        input busy;
        input wel;
        input [1:0] lvl;
        begin
            if (busy) begin
                status_byte = 8'hFF;
            end else begin
                status_byte = 8'h00;
                status_byte[`SEE_ST_BUSY]    = 1'b0;
                status_byte[`SEE_ST_LATCH]   = wel;
                status_byte[`SEE_ST_PROT_LO] = lvl[0];
                status_byte[`SEE_ST_PROT_HI] = lvl[1];
            end
        end
    endfunction

    wire [7:0] byte_in   = {shin_q, si_s};
    wire       byte_done = sck_r && (bit_cnt_q == 3'h7);
    wire [PAGE_AW-1:0] page_idx = addr_q[PAGE_AW-1:0];
    wire       out_ph    = is_out_phase(phase_q);
    wire       launch    = sck_f && out_ph;

    // ------------------------------------------------------------
    // Write termination points
    // ------------------------------------------------------------
    // Select must rise on a byte boundary; a partial byte means the
    // master gave up, so nothing is programmed.
    wire arr_term = phase_q == PH_WDAT && bit_cnt_q == 3'h0 &&
                    page_vld_q != {PAGE_N{1'b0}} && guard_s && !prog_busy;
    wire st_term  = phase_q == PH_STWR && bit_cnt_q == 3'h0 && rd_mode_q &&
                    guard_s && !prog_busy;

    // ------------------------------------------------------------
    // Array and page buffer storage
    // ------------------------------------------------------------
    // The cells carry no reset, so they live in a process of their own.
    wire                   page_load  = byte_done && phase_q == PH_WDAT;
    wire                   arr_commit = prog_done && prog_arr_q;
    wire [AW-PAGE_AW-1:0]  page_base  = addr_q[AW-1:PAGE_AW];

    always @(posedge clk) begin
        if (page_load) begin
            page_q[page_idx] <= byte_in;
        end
        if (arr_commit) begin
            for (i = 0; i < PAGE_N; i = i + 1) begin
                if (page_vld_q[i] &&
                    !is_protected({page_base, i[PAGE_AW-1:0]}, prot_q)) begin
                    mem[{page_base, i[PAGE_AW-1:0]}] <= page_q[i];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Serial sequence engine
    // ------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_q      <= PH_IDLE;
            bit_cnt_q    <= 3'h0;
            shin_q       <= 7'h00;
            shout_q      <= 8'h00;
            out_act_q    <= 1'b0;
            rd_mode_q    <= 1'b0;
            addr_q       <= {AW{1'b0}};
            wel_q        <= 1'b0;
            prot_q       <= `SEE_PROT_RESET;
            prot_new_q   <= 2'h0;
            prog_arr_q   <= 1'b0;
            prog_start_q <= 1'b0;
            page_vld_q   <= {PAGE_N{1'b0}};
        end else begin
            prog_start_q <= 1'b0;
            if (prog_done) begin
                wel_q <= 1'b0;
                if (!prog_arr_q) begin
                    prot_q <= prot_new_q;
                end
            end
            if (cs_fall) begin
                phase_q    <= PH_CMD;
                bit_cnt_q  <= 3'h0;
                out_act_q  <= 1'b0;
                page_vld_q <= prog_busy ? page_vld_q : {PAGE_N{1'b0}};
            end else if (cs_rise) begin
                if (arr_term) begin
                    prog_arr_q   <= 1'b1;
                    prog_start_q <= 1'b1;
                end else if (st_term) begin
                    prog_arr_q   <= 1'b0;
                    prog_start_q <= 1'b1;
                end
                // Any other point abandons the pending write.
                phase_q   <= PH_IDLE;
                out_act_q <= 1'b0;
            end else if (sck_r && phase_q != PH_DEAD && phase_q != PH_IDLE) begin
                bit_cnt_q <= bit_cnt_q + 3'h1;
                shin_q    <= byte_in[6:0];
                if (byte_done) begin
                    case (phase_q)
                        PH_CMD: begin
                            rd_mode_q <= 1'b0;
                            if (prog_busy && byte_in != `SEE_OP_STATUS_READ) begin
                                phase_q <= PH_DEAD;
                            end else begin
                                case (byte_in)
                                    `SEE_OP_LATCH_SET: begin
                                        wel_q   <= 1'b1;
                                        phase_q <= PH_DEAD;
                                    end
                                    `SEE_OP_LATCH_CLEAR: begin
                                        wel_q   <= 1'b0;
                                        phase_q <= PH_DEAD;
                                    end
                                    `SEE_OP_STATUS_READ: begin
                                        shout_q <= status_byte(prog_busy, wel_q, prot_q);
                                        phase_q <= PH_STOUT;
                                    end
                                    `SEE_OP_STATUS_WRITE: begin
                                        phase_q <= wel_q ? PH_STWR : PH_DEAD;
                                    end
                                    `SEE_OP_ARRAY_READ: begin
                                        rd_mode_q <= 1'b1;
                                        phase_q   <= PH_ADDR;
                                    end
                                    `SEE_OP_ARRAY_WRITE: begin
                                        phase_q <= wel_q ? PH_ADDR : PH_DEAD;
                                    end
                                    default: begin
                                        phase_q <= PH_DEAD;
                                    end
                                endcase
                            end
                        end
                        PH_ADDR: begin
                            addr_q <= byte_in[AW-1:0];
                            if (rd_mode_q) begin
                                shout_q <= mem[byte_in[AW-1:0]];
                                phase_q <= PH_RDAT;
                            end else begin
                                page_vld_q <= {PAGE_N{1'b0}};
                                phase_q    <= PH_WDAT;
                            end
                        end
                        PH_RDAT: begin
                            addr_q  <= addr_q + 1'b1;
                            shout_q <= mem[addr_q + 1'b1];
                        end
                        PH_STOUT: begin
                            shout_q <= status_byte(prog_busy, wel_q, prot_q);
                        end
                        PH_WDAT: begin
                            page_vld_q[page_idx] <= 1'b1;
                            addr_q[PAGE_AW-1:0]  <= page_idx + 1'b1;
                        end
                        PH_STWR: begin
                            if (!rd_mode_q) begin
                                prot_new_q <= byte_in[`SEE_ST_PROT_HI:`SEE_ST_PROT_LO];
                                rd_mode_q  <= 1'b1;
                            end else begin
                                rd_mode_q <= 1'b0;
                                phase_q   <= PH_DEAD;
                            end
                        end
                        default: begin
                            phase_q <= PH_DEAD;
                        end
                    endcase
                end
            end else if (launch) begin
                out_act_q <= 1'b1;
                shout_q   <= {shout_q[6:0], 1'b1};
            end
        end
    end

    // ------------------------------------------------------------
    // Serial output pin
    // ------------------------------------------------------------
    always @* begin
        so_d    = so_o;
        so_oe_d = 1'b0;
        if (launch) begin
            so_d = shout_q[7];
        end
        // Output stays off when deselected, suspended or after a bad command.
        if (!cs_s && hold_s && out_act_q &&
            out_ph) begin
            so_oe_d = 1'b1;
        end
        if (launch) begin
            so_oe_d = 1'b1;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            so_o  <= 1'b0;
            so_oe <= 1'b0;
        end else begin
            so_o  <= so_d;
            so_oe <= so_oe_d;
        end
    end
endmodule

// file: tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk, rst, guard_n, cs_n, sck, si, hold_n, so_o, so_oe;
    logic [7:0] rx, d, a;
    int         failures, checked, seed, lvl, mem[256];
    bit         wel;
    see_top #(.PROG_CYCLES(600)) DUT (.clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
        .guard_n(guard_n), .so_o(so_o), .so_oe(so_oe));
    see_master m (.clk(clk), .so_o(so_o), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            failures++;
            $display("FAIL at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task report_and_stop();
        $display("Counts: %0d compares, %0d mismatches", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    function logic [7:0] st();
        return {4'h0, 2'(lvl), wel, 1'b0};
    endfunction
    function bit prot(int x);
        return lvl == 3 || (lvl == 2 && x >= 'h80) || (lvl == 1 && x >= 'hC0);
    endfunction
    task cmd(input logic [7:0] op);
        m.sel();
        m.xfer(op, 8, 0, rx);
        m.desel();
    endtask
    task status_read_cmd(output logic [7:0] s);
        m.sel();
        m.xfer(8'h05, 8, 0, s);
        m.xfer(8'h00, 8, 0, s);
        m.desel();
    endtask
    // The device must stay silent for the whole frame.
    task refused(input logic [7:0] op);
        m.sel();
        m.xfer(op, 8, 0, rx);
        m.xfer(8'h00, 8, 0, rx);
        m.xfer(8'h00, 8, 0, rx);
        m.desel();
        chk({7'h0, m.oe_seen}, 8'h00);
    endtask
    task wait_ready();
        cmd(8'h06);
        refused(8'h03);
        status_read_cmd(rx);
        chk(rx, 8'hFF);
        for (int k = 0; k < 10 && rx === 8'hFF; k++) status_read_cmd(rx);
        chk(rx, st());
    endtask
    task wr(input logic [7:0] ad, input int n, input int nb);
        bit ok;
        ok = wel && guard_n;
        m.sel();
        m.xfer(8'h02, 8, 0, rx);
        m.xfer(ad, 8, 0, rx);
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            m.xfer(d, (i == n - 1) ? nb : 8, 0, rx);
            if (ok && nb == 8 && !prot({ad[7:2], 2'(ad + i)})) mem[{ad[7:2], 2'(ad + i)}] = d;
        end
        m.desel();
        if (ok && nb == 8) begin
            wel = 0;
            wait_ready();
        end else if (nb == 8) begin
            status_read_cmd(rx);
            chk(rx, st());
        end
    endtask
    task rd(input logic [7:0] ad, input int n, input bit hp);
        m.sel();
        m.xfer(8'h03, 8, 0, rx);
        m.xfer(ad, 8, 0, rx);
        for (int i = 0; i < n; i++) begin
            m.xfer(8'($random(seed)), 8, hp && i == 1, rx);
            if (mem[8'(ad + i)] >= 0) chk(rx, 8'(mem[8'(ad + i)]));
        end
        m.desel();
    endtask
    initial begin
        #(70000 * 50);
        failures++;
        $display("watchdog expired");
        report_and_stop();
    end
    initial begin
        seed = 43;
        failures = 0;
        checked = 0;
        lvl = 0;
        wel = 0;
        rst = 1'b1;
        guard_n = 1'b1;
        foreach (mem[i]) mem[i] = -1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        status_read_cmd(rx);
        chk(rx, st());
        cmd(8'h06);
        wel = 1;
        status_read_cmd(rx);
        chk(rx, st());
        cmd(8'h04);
        wel = 0;
        status_read_cmd(rx);
        chk(rx, st());
        wr(8'h40, 1, 8);
        refused(8'hA5);
        refused(8'hFF);
        $display("test latch and op-codes done");
        for (int v = 3; v >= 0; v--) begin
            cmd(8'h06);
            wel = 1;
            d = 8'($random(seed));
            d[3:2] = 2'(v);
            lvl = v;
            status_write_cmd_blk: begin
                m.sel();
                m.xfer(8'h01, 8, 0, rx);
                m.xfer(d, 8, 0, rx);
                m.desel();
                wel = 0;
                wait_ready();
            end
            for (int h = 2; h < 4; h++) begin
                cmd(8'h06);
                wel = 1;
                a = {2'(h), 6'($random(seed))};
                wr(a, 5, 8);
                rd({a[7:2], 2'h0}, 4, 0);
            end
        end
        $display("test protect levels and pages done");
        for (int p = 0; p < 2; p++) begin
            cmd(8'h06);
            wel = 1;
            wr(p ? 8'h00 : 8'hFC, 4, 8);
        end
        rd(8'hFE, 4, 1);
        chk({7'h0, m.hold_oe}, 8'h00);
        $display("test wrap and suspend done");
        @(posedge clk) guard_n <= 1'b0;
        cmd(8'h06);
        wel = 1;
        wr(8'h10, 1, 8);
        @(posedge clk) guard_n <= 1'b1;
        wr(8'hFD, 1, 4);
        status_read_cmd(rx);
        chk(rx & 8'h01, 8'h00);
        cmd(8'h04);
        wel = 0;
        rd(8'hFD, 1, 0);
        $display("test guard and abort done");
        report_and_stop();
    end
endmodule
